// >>> hdl/card_recorder_io_instruction_decode.sv
// I/O instruction decoder for the card data recorder attachment.
// Assumes one instruction pulse at a time from the processor channel,
// all inputs synchronous to clk_i.
`include "card_recorder_cfg.svh"

module card_recorder_io_instruction_decode (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire logic [2:0] instr_kind_i,
    input wire logic [7:0] control_byte_i,
    input wire logic control_parity_i,
    input wire logic [7:0] data_byte_i,
    input wire logic [15:0] load_address_i,
    input wire logic recorder_busy_i,
    input wire logic recorder_online_i,
    input wire logic recorder_ready_i,
    input wire logic io_check_i,
    input wire logic transport_jam_i,
    input wire logic feed_fault_i,
    input wire logic bad_card_code_i,
    input wire logic compare_error_i,
    input wire logic transfer_done_i,
    input wire logic [6:0] steals_taken_i,
    input wire logic print_switch_i,
    input wire logic [7:0] echo_byte_i,
    input wire logic steal_grant_i,
    output logic instr_done_o,
    output logic cond_a_o,
    output logic cond_b_o,
    output logic branch_o,
    output logic check_stop_o,
    output logic attention_o,
    output logic [15:0] store_data_o,
    output logic [15:0] transfer_address_register,
    output logic [7:0] recorder_status_byte,
    output logic [7:0] diag_byte_o,
    output logic diag_mode_o,
    output logic [7:0] outbound_bus_register,
    output logic read_cmd_o,
    output logic punch_cmd_o,
    output logic print_enable_o,
    output logic steal_req_o,
    output logic [7:0] steal_data_o
);
    card_recorder_pkg::state_t state, next_state;
    logic [2:0] kind, next_kind;
    logic [7:0] cbyte, next_cbyte;
    logic done, next_done, ca, next_ca, cb, next_cb, br, next_br;
    logic stop, next_stop, attn, next_attn, diag, next_diag, cmp5, next_cmp5;
    logic rd, next_rd, pu, next_pu, pr, next_pr, req, next_req;
    logic [15:0] sdata, next_sdata, tar, next_tar;
    logic [7:0] dbyte, next_dbyte, obr, next_obr, sbyte;
    logic sel, parity_ok, test_cond, busy_any;

    // Decode of address, parity and test condition
    always_comb begin
        sel = (control_byte_i[7:4] == `DEV_ADDR);
        parity_ok = ^{control_byte_i, control_parity_i};
        busy_any = recorder_busy_i | rd | pu | req;
        // Idle decodes the live byte; a looping advance must use the latched one,
        // since the channel no longer holds the control byte once it is taken
        test_cond = ((state == card_recorder_pkg::S_IDLE) ? control_byte_i[1] : cbyte[1]) ? busy_any
            : (io_check_i | ~recorder_ready_i);
        // Status byte: bit 0 of the byte sits on bit 7 of the port
        sbyte = 8'h00;
        sbyte[7 - `ST_OFFLINE] = ~recorder_online_i;
        sbyte[7 - `ST_JAM] = transport_jam_i;
        sbyte[7 - `ST_FEED] = feed_fault_i;
        sbyte[7 - `ST_CODE] = bad_card_code_i;
        sbyte[7 - `ST_COMPARE] = cmp5;
    end

    // Next-state logic of the instruction sequencer
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_cbyte = cbyte;
        next_done = 1'b0;
        next_ca = ca;
        next_cb = cb;
        next_br = 1'b0;
        next_stop = stop;
        next_attn = attn;
        next_diag = diag;
        next_cmp5 = cmp5;
        next_rd = rd;
        next_pu = pu;
        next_pr = pr;
        next_req = req;
        next_sdata = sdata;
        next_tar = tar;
        next_dbyte = dbyte;
        next_obr = obr;
        // Moving to online clears the attention lamp
        if (recorder_online_i) begin
            next_attn = 1'b0;
        end
        // Transfer end drops the recorder commands
        if (transfer_done_i) begin
            next_rd = 1'b0;
            next_pu = 1'b0;
            next_pr = 1'b0;
        end
        case (state)
            card_recorder_pkg::S_IDLE: begin
                // Only an addressed instruction seen while idle is taken
                if (instr_valid_i && sel) begin
                    next_kind = instr_kind_i;
                    next_cbyte = control_byte_i;
                    if (!parity_ok) begin
                        next_stop = 1'b1;
                        next_ca = 1'b1;
                        next_cb = 1'b1;
                        next_done = 1'b1;
                    end else begin
                        next_ca = 1'b0;
                        next_cb = 1'b0;
                        case (instr_kind_i)
                            card_recorder_pkg::INS_TEST: begin
                                next_ca = test_cond;
                                next_cb = ~test_cond;
                                next_br = test_cond;
                                next_done = 1'b1;
                            end
                            card_recorder_pkg::INS_ADVANCE: begin
                                if (control_byte_i[2:0] != 3'h0 && test_cond) begin
                                    next_state = card_recorder_pkg::S_WAIT;
                                end else begin
                                    next_cb = 1'b1;
                                    next_done = 1'b1;
                                end
                            end
                            card_recorder_pkg::INS_SENSE: begin
                                next_sdata = control_byte_i[1] ? {sbyte, dbyte} : tar;
                                next_cb = 1'b1;
                                next_done = 1'b1;
                            end
                            default: begin
                                if (instr_kind_i == card_recorder_pkg::INS_START && !recorder_online_i) begin
                                    next_attn = 1'b1;
                                    next_ca = 1'b1;
                                    next_done = 1'b1;
                                end else if (busy_any) begin
                                    next_state = card_recorder_pkg::S_WAIT;
                                end else begin
                                    next_state = card_recorder_pkg::S_STEAL;
                                end
                            end
                        endcase
                    end
                end
            end
            card_recorder_pkg::S_WAIT: begin
                // Stall loop for a busy load or start, or a looping advance
                if (kind == card_recorder_pkg::INS_ADVANCE) begin
                    if (!test_cond) begin
                        next_cb = 1'b1;
                        next_done = 1'b1;
                        next_state = card_recorder_pkg::S_IDLE;
                    end
                end else if (!busy_any) begin
                    next_state = card_recorder_pkg::S_STEAL;
                end
            end
            card_recorder_pkg::S_STEAL: begin
                // Execute an accepted load or start
                next_state = card_recorder_pkg::S_IDLE;
                next_done = 1'b1;
                if (kind == card_recorder_pkg::INS_LOAD) begin
                    next_tar = load_address_i;
                    next_cb = 1'b1;
                end else if (!recorder_ready_i || !recorder_online_i) begin
                    next_ca = 1'b1;
                end else begin
                    next_cb = 1'b1;
                    next_diag = 1'b0;
                    next_dbyte = 8'h00;
                    next_cmp5 = 1'b0;
                    case (cbyte[1:0])
                        2'h0: next_req = 1'b1;
                        2'h1: next_rd = 1'b1;
                        2'h2: begin
                            next_pu = 1'b1;
                            next_pr = print_switch_i;
                        end
                        default: begin
                            next_diag = 1'b1;
                            next_dbyte = data_byte_i;
                            next_obr = data_byte_i;
                        end
                    endcase
                end
            end
            default: next_state = card_recorder_pkg::S_IDLE;
        endcase
        // Error events follow the decode so that a set beats
        // the clear of a start executing in the same cycle
        if (compare_error_i) begin
            next_cmp5 = 1'b1;
        end
        if (transfer_done_i && (steals_taken_i != `STEAL_COUNT)) begin
            next_cmp5 = 1'b1;
        end
        // Echo from the recorder checked against the outbound byte
        if (diag && (echo_byte_i != obr)) begin
            next_cmp5 = 1'b1;
        end
        // Granted steal drops the request and steps the address
        if (req && steal_grant_i) begin
            next_req = 1'b0;
            next_tar = tar + 16'h0001;
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= card_recorder_pkg::S_IDLE;
            kind <= 3'h0;
            cbyte <= 8'h00;
            done <= 1'b0;
            ca <= 1'b0;
            cb <= 1'b0;
            br <= 1'b0;
            stop <= 1'b0;
            attn <= 1'b0;
            diag <= 1'b0;
            cmp5 <= 1'b0;
            rd <= 1'b0;
            pu <= 1'b0;
            pr <= 1'b0;
            req <= 1'b0;
            sdata <= 16'h0000;
            tar <= 16'h0000;
            dbyte <= 8'h00;
            obr <= 8'h00;
        end else if (ce_i) begin
            state <= next_state;
            kind <= next_kind;
            cbyte <= next_cbyte;
            done <= next_done;
            ca <= next_ca;
            cb <= next_cb;
            br <= next_br;
            stop <= next_stop;
            attn <= next_attn;
            diag <= next_diag;
            cmp5 <= next_cmp5;
            rd <= next_rd;
            pu <= next_pu;
            pr <= next_pr;
            req <= next_req;
            sdata <= next_sdata;
            tar <= next_tar;
            dbyte <= next_dbyte;
            obr <= next_obr;
        end
    end

    // Outputs
    assign instr_done_o = done;
    assign cond_a_o = ca;
    assign cond_b_o = cb;
    assign branch_o = br;
    assign check_stop_o = stop;
    assign attention_o = attn;
    assign store_data_o = sdata;
    assign transfer_address_register = tar;
    assign recorder_status_byte = sbyte;
    assign diag_byte_o = dbyte;
    assign diag_mode_o = diag;
    assign outbound_bus_register = obr;
    assign read_cmd_o = rd;
    assign punch_cmd_o = pu;
    assign print_enable_o = pr;
    assign steal_req_o = req;
    // Steal data is always the blank code; only diagnostic read steals
    assign steal_data_o = `BLANK_CODE;
endmodule : card_recorder_io_instruction_decode

// >>> hdl/card_recorder_cfg.svh
// Constants for the card recorder I/O instruction decoder.
// Assumes inclusion by bare name from the design files.
`ifndef CARD_RECORDER_CFG_SVH
`define CARD_RECORDER_CFG_SVH
`define DEV_ADDR 4'hf
`define BLANK_CODE 8'h40
`define STEAL_COUNT 7'h60
`define ST_OFFLINE 0
`define ST_JAM 1
`define ST_FEED 2
`define ST_CODE 4
`define ST_COMPARE 5
`endif

// >>> hdl/card_recorder_pkg.sv
// Types for the card recorder I/O instruction decoder.
// Assumes no surroundings beyond the compiler.
package card_recorder_pkg;
    typedef enum logic [2:0] {
        INS_LOAD, INS_TEST, INS_ADVANCE, INS_SENSE, INS_START
    } instr_t;
    typedef enum logic [1:0] {
        OP_DIAG_READ, OP_READ, OP_PUNCH, OP_DIAG_DATA
    } start_op_t;
    typedef enum {
        S_IDLE, S_WAIT, S_STEAL
    } state_t;
endpackage : card_recorder_pkg

// >>> verif/card_recorder_channel_model.sv
// Processor channel model: offers one I/O instruction at a time.
// Assumes the decoder answers on instr_done_o within the wait limit.
module card_recorder_channel_model (
    input wire logic clk_i,
    input wire logic done_i,
    input wire logic branch_i,
    output logic valid_o,
    output logic [2:0] kind_o,
    output logic [7:0] ctrl_o,
    output logic parity_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic got_done;
    logic got_branch;
    initial {valid_o, kind_o, ctrl_o, parity_o, got_done, got_branch} = '0;
    // Offer one pulse, scramble the released byte, wait a bounded time
    task automatic issue(input logic [2:0] kind, input logic [7:0] ctrl, input logic bad, input int lim);
        logic [7:0] c;
        c = {ctrl[7:4], 1'b0, kind == 3'h0 ? 3'h0 : ctrl[2:0]};
        @(posedge clk_i);
        #1;
        valid_o = 1'b1;
        kind_o = kind;
        ctrl_o = c;
        parity_o = ~^c ^ bad;
        @(posedge clk_i);
        #1;
        valid_o = 1'b0;
        ctrl_o = ~c;
        got_done = 1'b0;
        for (int i = 0; i < lim && got_done !== 1'b1; i++) begin
            got_done = done_i;
            got_branch = branch_i;
            if (got_done !== 1'b1) begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask : issue
endmodule : card_recorder_channel_model

// >>> verif/card_recorder_io_instruction_decode_properties.sv
// Checker for the card recorder instruction decoder ports.
// Assumes binding to the decoder top, one clock, sync reset.
module card_recorder_io_instruction_decode_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] control_byte_i,
    input wire logic control_parity_i,
    input wire logic recorder_online_i,
    input wire logic transport_jam_i,
    input wire logic feed_fault_i,
    input wire logic bad_card_code_i,
    input wire logic instr_done_o,
    input wire logic cond_a_o,
    input wire logic cond_b_o,
    input wire logic branch_o,
    input wire logic check_stop_o,
    input wire logic attention_o,
    input wire logic [7:0] recorder_status_byte,
    input wire logic print_enable_o,
    input wire logic punch_cmd_o,
    input wire logic steal_req_o,
    input wire logic [7:0] steal_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Addressed instruction with broken odd parity
    sequence bad_parity_s;
        instr_valid_i && ce_i && control_byte_i[7:4] == 4'hf && !(^{control_byte_i, control_parity_i});
    endsequence
    // Instruction meant for another unit
    sequence foreign_s;
        instr_valid_i && control_byte_i[7:4] != 4'hf;
    endsequence
    stop_on_parity_a: assert property (bad_parity_s |-> ##[1:2] check_stop_o)
        else $error("no check stop after parity error");
    stop_sticky_a: assert property (check_stop_o |=> check_stop_o)
        else $error("check stop dropped");
    foreign_quiet_a: assert property (foreign_s |=> !instr_done_o)
        else $error("answer to foreign address");
    attention_clear_a: assert property (ce_i && recorder_online_i |=> !attention_o)
        else $error("attention kept while online");
    branch_done_a: assert property (branch_o |-> instr_done_o)
        else $error("branch without completion");
    cond_both_a: assert property (cond_a_o && cond_b_o |-> check_stop_o)
        else $error("both conditions without parity stop");
    status_bits_a: assert property (recorder_status_byte[7:3] ==
        {~recorder_online_i, transport_jam_i, feed_fault_i, 1'b0, bad_card_code_i})
        else $error("status byte bits wrong");
    print_punch_a: assert property (print_enable_o |-> punch_cmd_o)
        else $error("printing outside punch");
    steal_blank_a: assert property (steal_req_o |-> steal_data_o == 8'h40 && !punch_cmd_o && !print_enable_o)
        else $error("steal data not blank or card moving");
endmodule : card_recorder_io_instruction_decode_properties
bind card_recorder_io_instruction_decode card_recorder_io_instruction_decode_properties chk (.*);

// >>> verif/card_recorder_io_instruction_decode_tb.sv
// Self-checking bench for the card recorder instruction decoder.
// Assumes the channel model and the bound checker are compiled with it.
module card_recorder_io_instruction_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [2:0] kind; logic [2:0] fn; logic busy; logic ready; logic [2:0] abr;} row_t;
    localparam row_t ROWS [8] = '{'{3'h1, 3'h2, 1'b1, 1'b1, 3'h5}, '{3'h1, 3'h2, 1'b0, 1'b1, 3'h2},
        '{3'h1, 3'h0, 1'b0, 1'b0, 3'h5}, '{3'h1, 3'h0, 1'b1, 1'b1, 3'h2}, '{3'h3, 3'h0, 1'b1, 1'b0, 3'h2},
        '{3'h2, 3'h0, 1'b1, 1'b1, 3'h2}, '{3'h2, 3'h2, 1'b0, 1'b1, 3'h2}, '{3'h4, 3'h1, 1'b0, 1'b0, 3'h4}};
    logic clk_i, rst_i, ce_i, instr_valid_i, control_parity_i, recorder_busy_i, recorder_online_i;
    logic recorder_ready_i, io_check_i, transport_jam_i, feed_fault_i, bad_card_code_i, compare_error_i;
    logic transfer_done_i, print_switch_i, steal_grant_i, instr_done_o, cond_a_o, cond_b_o, branch_o;
    logic check_stop_o, attention_o, diag_mode_o, read_cmd_o, punch_cmd_o, print_enable_o, steal_req_o;
    logic [2:0] instr_kind_i;
    logic [6:0] steals_taken_i;
    logic [7:0] control_byte_i, data_byte_i, echo_byte_i, recorder_status_byte, diag_byte_o;
    logic [7:0] outbound_bus_register, steal_data_o, echo_flip;
    logic [15:0] load_address_i, store_data_o, transfer_address_register;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    card_recorder_io_instruction_decode dut (.*);
    card_recorder_channel_model chan (.clk_i(clk_i), .done_i(instr_done_o), .branch_i(branch_o),
        .valid_o(instr_valid_i), .kind_o(instr_kind_i), .ctrl_o(control_byte_i), .parity_o(control_parity_i));
    // Recorder echoes the outbound byte, optionally corrupted
    assign echo_byte_i = outbound_bus_register ^ echo_flip;
    always #5 clk_i = ~clk_i;
    // Cycle ceiling against hangs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic end_xfer(input logic [6:0] n);
        steals_taken_i = n;
        transfer_done_i = 1'b1;
        tick(1);
        transfer_done_i = 1'b0;
        tick(2);
    endtask : end_xfer
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Main sequence: table rows first, then hand-written cases
    initial begin
        {clk_i, recorder_busy_i, io_check_i, transport_jam_i, feed_fault_i, bad_card_code_i} = '0;
        {compare_error_i, transfer_done_i, print_switch_i, steal_grant_i, steals_taken_i} = '0;
        {data_byte_i, load_address_i, echo_flip} = '0;
        {ce_i, recorder_online_i, recorder_ready_i, rst_i} = 4'hf;
        tick(10);
        rst_i = 1'b0;
        check("reset", 16'({cond_a_o, cond_b_o, check_stop_o, attention_o, diag_mode_o}), 16'h0000);
        foreach (ROWS[i]) begin
            recorder_busy_i = ROWS[i].busy;
            recorder_ready_i = ROWS[i].ready;
            chan.issue(ROWS[i].kind, {5'h1e, ROWS[i].fn}, 1'b0, 20);
            check("row", 16'({chan.got_done, cond_a_o, cond_b_o, chan.got_branch}), 16'({1'b1, ROWS[i].abr}));
        end
        chan.issue(3'h3, 8'he2, 1'b0, 8);
        check("foreign", 16'({chan.got_done, diag_mode_o}), 16'h0000);
        {recorder_busy_i, recorder_ready_i, load_address_i} = {2'b11, 16'h1234};
        fork
            chan.issue(3'h0, 8'hf0, 1'b0, 40);
            begin
                tick(6);
                check("stall", 16'(instr_done_o), 16'h0000);
                recorder_busy_i = 1'b0;
            end
        join
        check("load", transfer_address_register, 16'h1234);
        recorder_busy_i = 1'b1;
        fork
            chan.issue(3'h2, 8'hf2, 1'b0, 40);
            begin
                tick(6);
                check("loop", 16'(instr_done_o), 16'h0000);
                recorder_busy_i = 1'b0;
            end
        join
        check("advance", 16'({chan.got_done, cond_b_o}), 16'h0003);
        chan.issue(3'h3, 8'hf0, 1'b0, 20);
        check("sense addr", store_data_o, 16'h1234);
        chan.issue(3'h4, 8'hf0, 1'b0, 20);
        for (int i = 0; i < 20 && steal_req_o !== 1'b1; i++) tick(1);
        check("blank", 16'({steal_req_o, steal_data_o}), 16'h0140);
        steal_grant_i = 1'b1;
        tick(1);
        steal_grant_i = 1'b0;
        tick(3);
        check("steal", 16'({steal_req_o, transfer_address_register[14:0]}), 16'h1235);
        chan.issue(3'h4, 8'hf1, 1'b0, 20);
        check("read", 16'({read_cmd_o, punch_cmd_o}), 16'h0002);
        end_xfer(7'h5f);
        check("short", 16'(recorder_status_byte[2]), 16'h0001);
        print_switch_i = 1'b1;
        chan.issue(3'h4, 8'hf2, 1'b0, 20);
        check("punch", 16'({punch_cmd_o, print_enable_o}), 16'h0003);
        end_xfer(7'h60);
        check("no short", 16'(recorder_status_byte[2]), 16'h0000);
        compare_error_i = 1'b1;
        tick(1);
        compare_error_i = 1'b0;
        check("compare", 16'(recorder_status_byte[2]), 16'h0001);
        {transport_jam_i, bad_card_code_i, data_byte_i} = {2'b11, 8'h5a};
        chan.issue(3'h4, 8'hf3, 1'b0, 20);
        check("diag", 16'({diag_mode_o, diag_byte_o}), 16'h015a);
        chan.issue(3'h3, 8'hf2, 1'b0, 20);
        check("status", {store_data_o[15:11], store_data_o[7:0]}, 16'h095a);
        echo_flip = 8'h01;
        tick(3);
        check("echo", 16'({recorder_status_byte[2], diag_mode_o}), 16'h0003);
        {echo_flip, transport_jam_i, bad_card_code_i, recorder_busy_i} = 11'h001;
        fork
            chan.issue(3'h4, 8'hf1, 1'b0, 40);
            begin
                tick(6);
                check("held", 16'(instr_done_o), 16'h0000);
                recorder_busy_i = 1'b0;
            end
        join
        check("retry", 16'({cond_b_o, diag_mode_o}), 16'h0002);
        end_xfer(7'h60);
        {recorder_online_i, recorder_ready_i} = 2'b00;
        chan.issue(3'h4, 8'hf1, 1'b0, 20);
        check("offline", 16'({attention_o, cond_a_o}), 16'h0003);
        recorder_online_i = 1'b1;
        tick(2);
        check("online", 16'(attention_o), 16'h0000);
        ce_i = 1'b0;
        chan.issue(3'h3, 8'hf0, 1'b0, 4);
        ce_i = 1'b1;
        check("frozen", 16'({chan.got_done, store_data_o[14:0]}), 16'h485a);
        chan.issue(3'h1, 8'hf2, 1'b1, 20);
        check("parity", 16'({check_stop_o, cond_a_o, cond_b_o}), 16'h0007);
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        check("rereset", 16'({check_stop_o, attention_o, diag_mode_o}), 16'h0000);
        stop_test();
    end
endmodule : card_recorder_io_instruction_decode_tb
